/* pkg/smdl_pkg.sv */
// Constants for the scan map, delay and lower-limit register bank
package smdl_pkg;
  // Register indices as addressed on the parallel regAddr port
  localparam int         ADDR_W         = 5;
  localparam int         DATA_W         = 24;
  localparam logic [4:0] OFS_CHMAP_LOW  = 5'h06;
  localparam logic [4:0] OFS_DELAY_CFG  = 5'h07;
  localparam logic [4:0] OFS_BOUND_CH0  = 5'h08;
  localparam logic [4:0] OFS_BOUND_CH1  = 5'h09;
  localparam logic [4:0] OFS_BOUND_CH2  = 5'h0A;

  // Reset values
  localparam logic [23:0] RST_CHMAP     = 24'h000000;
  localparam logic [23:0] RST_DELAY     = 24'h000000;
  localparam logic [23:0] RST_BOUND     = 24'h000000;

  // Per-channel slice of the channel map, channel n at n*CH_SLICE_W
  localparam int CH_SLICE_W  = 8;
  localparam int SEL_LSB     = 5;
  localparam int ORD_LSB     = 2;
  localparam int EN_BIT      = 1;
  localparam int OEN_BIT     = 0;
  localparam int FIELD_W     = 3;

  // Scan order codes
  localparam logic [2:0] ORD_FIRST   = 3'h1;
  localparam logic [2:0] ORD_LAST    = 3'h6;
  localparam logic [2:0] ORD_UNSET   = 3'h0;
  localparam logic [2:0] ORD_BEYOND  = 3'h7;

  // Delay field positions
  localparam int AUTO_LSB    = 16;
  localparam int MUX_LSB     = 8;
  localparam int OUT_LSB     = 0;
  localparam int DLY_W       = 8;

  // Clock and delay step sizes
  localparam int CLK_MHZ      = 200;
  localparam int AUTO_STEP_MS = 4;
  localparam int MUX_STEP_US  = 4;
  localparam int OUT_STEP_US  = 20;
  localparam int AUTO_STEP_CYC = AUTO_STEP_MS * 1000 * CLK_MHZ;
  localparam int MUX_STEP_CYC  = MUX_STEP_US * CLK_MHZ;
  localparam int OUT_STEP_CYC  = OUT_STEP_US * CLK_MHZ;

  // Sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_SELECT, SEQ_SWITCH, SEQ_OUTDLY, SEQ_CONVERT, SEQ_PASS
  } smdl_state_t;
endpackage

/* core/smdl_delay_timer.sv */
// Programmable step delay timer: code times step cycles, zero means none
`timescale 1ns/1ps
`default_nettype none
module smdl_delay_timer
  import smdl_pkg::*;
#(
  parameter int STEP_CYCLES = 800,
  parameter int PRE_W       = 20
) (
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic             start,
  input  wire logic [DLY_W-1:0] code,
  output logic                  busy,
  output logic                  done
);
  localparam logic [PRE_W-1:0] PRE_LOAD = PRE_W'(STEP_CYCLES - 1);

  logic [PRE_W-1:0] pre;
  logic [DLY_W-1:0] left;
  logic             next_busy;
  logic [PRE_W-1:0] next_pre;
  logic [DLY_W-1:0] next_left;

  // Step prescaler and remaining-step count
  always_comb begin
    next_busy = busy;
    next_pre  = pre;
    next_left = left;
    done      = 1'b0;
    if (!busy) begin
      if (start) begin
        if (code == '0) begin
          done = 1'b1;                 // No delay for a zero code
        end else begin
          next_busy = 1'b1;
          next_pre  = PRE_LOAD;
          next_left = code;
        end
      end
    end else if (pre == '0) begin
      if (left == DLY_W'(1)) begin
        done      = 1'b1;
        next_busy = 1'b0;
      end else begin
        next_left = left - DLY_W'(1);
        next_pre  = PRE_LOAD;
      end
    end else begin
      next_pre = pre - PRE_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      busy <= 1'b0;
      pre  <= '0;
      left <= '0;
    end else begin
      busy <= next_busy;
      pre  <= next_pre;
      left <= next_left;
    end
  end

  a_zero_no_delay: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!busy && start && code == '0) |-> done && !next_busy)
    else $error("zero delay code did not finish at once");
  a_no_early_done: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!busy && start && code != '0) |=> !done)
    else $error("timer finished one cycle after start");
endmodule
`default_nettype wire

/* core/smdl_scan_regs.sv */
// Scan map, delay and lower-limit registers with their scan sequencer
//
// Behaviour
// - Map register packs ch2..ch0 select, order, enable, output enable; zero reset.
// - Autoscan field bits 23:16, 4 ms steps; zero gives no delay.
// - Input-switch field bits 15:8, 4 us steps; zero gives no delay.
// - Output-control field bits 7:0, 20 us steps; zero gives no delay.
// - Three 24-bit read/write lower-limit registers, one per channel, zero reset.
// - Each channel's result is compared against its own lower limit.
// - Enabled channel with order 000 or 111 raises the order error flag.
// - Two enabled outputs sharing one output select raise the mapping error.
// - Map register ignores writes during scan; host writes only when idle.
// - Selected channel with output enable drives its selected output pin.
`timescale 1ns/1ps
`default_nettype none
module smdl_scan_regs
  import smdl_pkg::*;
#(
  parameter int NUM_CH      = 3,
  parameter int NUM_OUT     = 8,
  parameter int AUTO_CYC    = AUTO_STEP_CYC,
  parameter int MUX_CYC     = MUX_STEP_CYC,
  parameter int OUT_CYC     = OUT_STEP_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  output logic      [DATA_W-1:0] regRdData,
  input  wire logic              scanStart,
  input  wire logic              scanRepeat,
  output logic                   scanActive,
  output logic                   convStart,
  input  wire logic              convDone,
  input  wire logic [DATA_W-1:0] convResult,
  output logic      [1:0]        curChannel,
  output logic      [NUM_OUT-1:0] outPins,
  output logic                   limitLowHit,
  output logic      [1:0]        limitLowCh,
  output logic                   order_error_flag,
  output logic                   output_mapping_error_flag
);
  logic [DATA_W-1:0] scan_channel_map_low;
  logic [DATA_W-1:0] scan_delay_config;
  logic [DATA_W-1:0] lowerBound [NUM_CH];
  smdl_state_t       state;
  logic [2:0]        orderStep;
  logic              armed;

  // Field extraction for channel ch
  function automatic logic [2:0] fieldSel(input logic [23:0] m,
                                          input int ch);
    fieldSel = m[ch*CH_SLICE_W+SEL_LSB +: FIELD_W];
  endfunction
  function automatic logic [2:0] fieldOrd(input logic [23:0] m,
                                          input int ch);
    fieldOrd = m[ch*CH_SLICE_W+ORD_LSB +: FIELD_W];
  endfunction
  function automatic logic fieldEn(input logic [23:0] m, input int ch);
    fieldEn = m[ch*CH_SLICE_W+EN_BIT];
  endfunction
  function automatic logic fieldOen(input logic [23:0] m, input int ch);
    fieldOen = m[ch*CH_SLICE_W+OEN_BIT];
  endfunction

  // Delay timers
  logic muxStart, muxDone, outStart, outDone, autoStart, autoDone;
  smdl_delay_timer #(.STEP_CYCLES(MUX_CYC), .PRE_W(20)) u_muxDly (
    .core_clk(core_clk), .rst_b(rst_b), .start(muxStart),
    .code(scan_delay_config[MUX_LSB +: DLY_W]),
    .busy(), .done(muxDone));
  smdl_delay_timer #(.STEP_CYCLES(OUT_CYC), .PRE_W(20)) u_outDly (
    .core_clk(core_clk), .rst_b(rst_b), .start(outStart),
    .code(scan_delay_config[OUT_LSB +: DLY_W]),
    .busy(), .done(outDone));
  smdl_delay_timer #(.STEP_CYCLES(AUTO_CYC), .PRE_W(32)) u_autoDly (
    .core_clk(core_clk), .rst_b(rst_b), .start(autoStart),
    .code(scan_delay_config[AUTO_LSB +: DLY_W]),
    .busy(), .done(autoDone));

  // Map error checks and channel lookup by order
  logic       ordErr, mapErr, anyEn, found;
  logic [1:0] foundCh;
  always_comb begin
    ordErr  = 1'b0;
    mapErr  = 1'b0;
    anyEn   = 1'b0;
    found   = 1'b0;
    foundCh = 2'h0;
    for (int i = 0; i < NUM_CH; i++) begin
      anyEn = anyEn | fieldEn(scan_channel_map_low, i);
      if (fieldEn(scan_channel_map_low, i) &&
          (fieldOrd(scan_channel_map_low, i) == ORD_UNSET ||
           fieldOrd(scan_channel_map_low, i) == ORD_BEYOND))
        ordErr = 1'b1;
      for (int j = i + 1; j < NUM_CH; j++)
        if (fieldOen(scan_channel_map_low, i) &&
            fieldOen(scan_channel_map_low, j) &&
            fieldSel(scan_channel_map_low, i) ==
            fieldSel(scan_channel_map_low, j))
          mapErr = 1'b1;
      if (!found && fieldEn(scan_channel_map_low, i) &&
          fieldOrd(scan_channel_map_low, i) == orderStep) begin
        found   = 1'b1;
        foundCh = 2'(i);
      end
    end
  end

  // Sequencer next state
  smdl_state_t next_state;
  logic [2:0]  next_orderStep;
  logic        next_armed;
  logic [1:0]  next_curChannel;
  logic [NUM_OUT-1:0] next_outPins;
  logic        next_limitLowHit;
  logic [1:0]  next_limitLowCh;
  always_comb begin
    next_state       = state;
    next_orderStep   = orderStep;
    next_armed       = armed;
    next_curChannel  = curChannel;
    next_outPins     = outPins;
    next_limitLowHit = 1'b0;
    next_limitLowCh  = limitLowCh;
    muxStart  = 1'b0;
    outStart  = 1'b0;
    autoStart = 1'b0;
    convStart = 1'b0;
    case (state)
      SEQ_IDLE: begin
        if (scanStart && anyEn && !ordErr && !mapErr) begin
          next_orderStep = ORD_FIRST;
          next_state     = SEQ_SELECT;
        end
      end
      SEQ_SELECT: begin
        next_armed = 1'b0;
        if (orderStep > ORD_LAST) begin
          next_state = SEQ_PASS;
        end else if (found) begin
          next_curChannel = foundCh;
          next_state      = SEQ_SWITCH;
        end else begin
          next_orderStep = orderStep + 3'h1;
        end
      end
      SEQ_SWITCH: begin
        muxStart   = !armed;
        next_armed = 1'b1;
        if (muxDone) begin
          next_armed = 1'b0;
          if (fieldOen(scan_channel_map_low, int'(curChannel))) begin
            next_outPins = NUM_OUT'(1) <<
              fieldSel(scan_channel_map_low, int'(curChannel));
            next_state   = SEQ_OUTDLY;
          end else begin
            next_state = SEQ_CONVERT;
          end
        end
      end
      SEQ_OUTDLY: begin
        outStart   = !armed;
        next_armed = 1'b1;
        if (outDone) begin
          next_armed = 1'b0;
          next_state = SEQ_CONVERT;
        end
      end
      SEQ_CONVERT: begin
        convStart  = !armed;
        next_armed = 1'b1;
        if (armed && convDone) begin
          next_armed       = 1'b0;
          next_limitLowHit = $signed(convResult) <
                             $signed(lowerBound[curChannel]);
          next_limitLowCh  = curChannel;
          next_outPins     = '0;
          next_orderStep   = orderStep + 3'h1;
          next_state       = SEQ_SELECT;
        end
      end
      SEQ_PASS: begin
        autoStart  = scanRepeat && !armed;
        next_armed = 1'b1;
        if (!scanRepeat) begin
          next_armed = 1'b0;
          next_state = SEQ_IDLE;
        end else if (autoDone) begin
          next_armed     = 1'b0;
          next_orderStep = ORD_FIRST;
          next_state     = SEQ_SELECT;
        end
      end
      default: next_state = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state       <= SEQ_IDLE;
      orderStep   <= ORD_FIRST;
      armed       <= 1'b0;
      curChannel  <= 2'h0;
      outPins     <= '0;
      limitLowHit <= 1'b0;
      limitLowCh  <= 2'h0;
      order_error_flag          <= 1'b0;
      output_mapping_error_flag <= 1'b0;
    end else begin
      state       <= next_state;
      orderStep   <= next_orderStep;
      armed       <= next_armed;
      curChannel  <= next_curChannel;
      outPins     <= next_outPins;
      limitLowHit <= next_limitLowHit;
      limitLowCh  <= next_limitLowCh;
      order_error_flag          <= ordErr;
      output_mapping_error_flag <= mapErr;
    end
  end

  assign scanActive = (state != SEQ_IDLE);

  // Register writes and read data
  logic [DATA_W-1:0] next_map, next_dly, next_rd;
  logic [DATA_W-1:0] next_bound [NUM_CH];
  always_comb begin
    next_map = scan_channel_map_low;
    next_dly = scan_delay_config;
    next_rd  = regRdData;
    for (int i = 0; i < NUM_CH; i++)
      next_bound[i] = lowerBound[i];
    if (regWrEn) begin
      case (regAddr)
        OFS_CHMAP_LOW: if (!scanActive) next_map = regWrData;
        OFS_DELAY_CFG: next_dly = regWrData;
        OFS_BOUND_CH0: next_bound[0] = regWrData;
        OFS_BOUND_CH1: next_bound[1] = regWrData;
        OFS_BOUND_CH2: next_bound[2] = regWrData;
        default: ;
      endcase
    end
    if (regRdEn) begin
      case (regAddr)
        OFS_CHMAP_LOW: next_rd = scan_channel_map_low;
        OFS_DELAY_CFG: next_rd = scan_delay_config;
        OFS_BOUND_CH0: next_rd = lowerBound[0];
        OFS_BOUND_CH1: next_rd = lowerBound[1];
        OFS_BOUND_CH2: next_rd = lowerBound[2];
        default:       next_rd = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      scan_channel_map_low <= RST_CHMAP;
      scan_delay_config    <= RST_DELAY;
      regRdData            <= '0;
      for (int i = 0; i < NUM_CH; i++)
        lowerBound[i] <= RST_BOUND;
    end else begin
      scan_channel_map_low <= next_map;
      scan_delay_config    <= next_dly;
      regRdData            <= next_rd;
      for (int i = 0; i < NUM_CH; i++)
        lowerBound[i] <= next_bound[i];
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_map_write_lock: assert property (
    scanActive && regWrEn && regAddr == OFS_CHMAP_LOW
    |=> $stable(scan_channel_map_low))
    else $error("map register changed during scan");
  a_map_write_take: assert property (
    !scanActive && regWrEn && regAddr == OFS_CHMAP_LOW
    |=> scan_channel_map_low == $past(regWrData))
    else $error("map register write lost while idle");
  a_bound_write: assert property (
    regWrEn && regAddr == OFS_BOUND_CH1
    |=> lowerBound[1] == $past(regWrData))
    else $error("lower bound write lost");
  a_order_error: assert property (
    fieldEn(scan_channel_map_low, 0) &&
    fieldOrd(scan_channel_map_low, 0) == ORD_BEYOND |=> order_error_flag)
    else $error("order error flag missing");
  a_map_error: assert property (
    output_mapping_error_flag |-> $past(mapErr))
    else $error("mapping error flag without cause");
  a_no_scan_on_err: assert property (
    state == SEQ_IDLE && (ordErr || mapErr) |=> state == SEQ_IDLE)
    else $error("scan started with map error");
  a_compare_low: assert property (
    state == SEQ_CONVERT && armed && convDone
    |=> limitLowHit == ($signed($past(convResult)) <
                        $signed($past(lowerBound[curChannel]))))
    else $error("lower limit compare wrong");
  a_out_pin_drive: assert property (
    state == SEQ_OUTDLY |-> outPins ==
      (NUM_OUT'(1) << fieldSel(scan_channel_map_low, int'(curChannel))))
    else $error("output pin not driven for channel");
  a_zero_mux_skip: assert property (
    state == SEQ_SWITCH && !armed &&
    scan_delay_config[MUX_LSB +: DLY_W] == '0 |=> state != SEQ_SWITCH)
    else $error("zero switch delay still waited");
  a_switch_wait: assert property (
    state == SEQ_SWITCH && !armed &&
    scan_delay_config[MUX_LSB +: DLY_W] != '0 |=> state == SEQ_SWITCH)
    else $error("switch delay skipped");

  c_full_conv: cover property (state == SEQ_CONVERT && armed && convDone);
  c_low_hit: cover property (limitLowHit);
  c_repeat: cover property (state == SEQ_PASS && autoDone);
  c_out_drive: cover property (state == SEQ_OUTDLY && outDone);
endmodule
`default_nettype wire

/* testbench/smdl_conv_model.sv */
// Converter model answering conversion requests after a set latency
`timescale 1ns/1ps
`default_nettype none
module smdl_conv_model
  import smdl_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              convStart,
  input  wire logic              slow,
  input  wire logic [DATA_W-1:0] resVal,
  output logic                   convDone,
  output logic      [DATA_W-1:0] convResult
);
  logic [3:0] cnt;

  // Count the conversion time, then pulse done with the result
  always_ff @(posedge core_clk) begin
    convDone   <= 1'b0;
    convResult <= ~convResult;  // No stale result between answers
    if (!rst_b) begin
      cnt        <= 4'h0;
      convResult <= 24'h5A5A5A;
    end else if (convStart) begin
      cnt <= slow ? 4'h6 : 4'h1;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        convDone   <= 1'b1;
        convResult <= resVal;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_smdl_scan_regs.sv */
// Testbench for the scan map, delay and lower-limit register bank
`timescale 1ns/1ps
`default_nettype none
module tb_smdl_scan_regs
  import smdl_pkg::*;
;
  localparam int MUXC  = 2;
  localparam int OUTC  = 3;
  localparam int AUTOC = 4;
  logic              core_clk, rst_b, regWrEn, regRdEn, slow;
  logic              scanStart, scanRepeat, scanActive, convStart;
  logic              convDone, limitLowHit, oErr, mErr;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData, convResult, resVal;
  logic [1:0]        curChannel, limitLowCh;
  logic [7:0]        outPins, pinSeen;
  logic [2:0]        hitMask;
  logic [5:0]        chSeq;
  int                nErrors, nTests, ta, i, j;

  smdl_scan_regs #(.AUTO_CYC(AUTOC), .MUX_CYC(MUXC), .OUT_CYC(OUTC))
    u_smdl_scan_regs (.core_clk(core_clk), .rst_b(rst_b),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .scanStart(scanStart),
    .scanRepeat(scanRepeat), .scanActive(scanActive),
    .convStart(convStart), .convDone(convDone), .convResult(convResult),
    .curChannel(curChannel), .outPins(outPins),
    .limitLowHit(limitLowHit), .limitLowCh(limitLowCh),
    .order_error_flag(oErr), .output_mapping_error_flag(mErr));

  smdl_conv_model u_smdl_conv_model (.core_clk(core_clk), .rst_b(rst_b),
    .convStart(convStart), .slow(slow), .resVal(resVal),
    .convDone(convDone), .convResult(convResult));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Log channel order, pins and limit hits
  always @(posedge core_clk) begin
    if (convStart === 1'b1) begin
      chSeq   <= {chSeq[3:0], curChannel};
      pinSeen <= outPins;
    end
    if (scanStart === 1'b1) hitMask <= '0;
    if (limitLowHit === 1'b1) hitMask[limitLowCh] <= 1'b1;
  end

  function automatic logic [23:0] slot(int ch, logic [2:0] sel, ord,
                                       logic en, oen);
    return 24'({sel, ord, en, oen}) << (ch * CH_SLICE_W);
  endfunction

  task automatic chk(string nm, logic [23:0] got, logic [23:0] e);
    nTests++;
    if (got !== e) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, got);
    end
  endtask

  task automatic wr(logic [4:0] a, logic [23:0] d);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask

  task automatic rdc(logic [4:0] a, logic [23:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1 chk("regRdData", regRdData, e);
  endtask

  // Cycles from scan request to the first conversion start
  task automatic runTo(output int c);
    c = 0;
    @(posedge core_clk);
    scanStart <= 1'b1;
    do begin
      @(posedge core_clk);
      scanStart <= 1'b0;
      #1 c++;
    end while (convStart !== 1'b1 && c < 400);
  endtask

  task automatic nextConv(output int c);
    c = 0;
    do begin
      @(posedge core_clk);
      #1 c++;
    end while (convStart !== 1'b1 && c < 400);
  endtask

  task automatic idle();
    for (int k = 0; k < 400 && scanActive !== 1'b0; k++) begin
      @(posedge core_clk);
    end
    #1 chk("scanActive", {23'h0, scanActive}, 24'h0);
  endtask

  // Timing difference between two delay settings
  task automatic meas(logic [23:0] d1, d2, logic rep, output int dt);
    int c[2];
    for (int k = 0; k < 2; k++) begin
      wr(OFS_DELAY_CFG, k ? d2 : d1);
      scanRepeat <= rep;
      runTo(c[k]);
      if (rep) nextConv(c[k]);
      scanRepeat <= 1'b0;
      idle();
    end
    dt = c[1] - c[0];
  endtask

  task automatic conclude();
    if (nErrors == 0 && nTests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog against a hung scan
  initial begin
    repeat (20000) @(posedge core_clk);
    nErrors++;
    conclude();
  end

  initial begin
    {rst_b, regWrEn, regRdEn, scanStart, scanRepeat, slow} = '0;
    regAddr   = '0;
    regWrData = '0;
    resVal    = '0;
    nErrors   = 0;
    nTests    = 0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    // Reset values, then two patterns written and read back
    for (i = 6; i <= 10; i++) rdc(5'(i), 24'h000000);
    for (j = 0; j < 2; j++) begin
      for (i = 6; i <= 10; i++) begin
        wr(5'(i), (j ? 24'h5A3CA5 : 24'hA5C35A) ^ 24'(i));
        rdc(5'(i), (j ? 24'h5A3CA5 : 24'hA5C35A) ^ 24'(i));
      end
    end
    // Unmapped index neither reads nor disturbs
    wr(5'h0B, 24'h123456);
    rdc(5'h0B, 24'h000000);
    rdc(OFS_BOUND_CH2, 24'h5A3CA5 ^ 24'h00000A);
    // Every order code on every enabled channel
    for (i = 0; i < 3; i++) begin
      for (j = 0; j < 8; j++) begin
        wr(OFS_CHMAP_LOW, slot(i, 3'h0, 3'(j), 1'b1, 1'b0));
        @(posedge core_clk);
        #1 chk("orderErr", {23'h0, oErr}, 24'(j == 0 || j == 7));
      end
    end
    // Scan request refused while the order error stands
    @(posedge core_clk);
    scanStart <= 1'b1;
    @(posedge core_clk);
    scanStart <= 1'b0;
    #1 chk("errBlock", {23'h0, scanActive}, 24'h000000);
    wr(OFS_CHMAP_LOW, slot(1, 3'h0, 3'h7, 1'b0, 1'b0));
    @(posedge core_clk);
    #1 chk("orderErr", {23'h0, oErr}, 24'h000000);
    // Shared output select with outputs enabled
    for (j = 0; j < 3; j++) begin
      wr(OFS_CHMAP_LOW, slot(0, 3'h2, 3'h1, 1'b1, 1'b1)
                      | slot(2, 3'(2 + j[0]), 3'h2, 1'b1, j < 2));
      @(posedge core_clk);
      #1 chk("mapErr", {23'h0, mErr}, 24'(j == 0));
    end
    // Zero delays add nothing, no pin without output enable
    wr(OFS_CHMAP_LOW, slot(0, 3'h5, 3'h1, 1'b1, 1'b0));
    wr(OFS_DELAY_CFG, 24'h000000);
    runTo(ta);
    idle();
    chk("startCycles", 24'(ta), 24'h000003);
    chk("pins", 24'(pinSeen), 24'h000000);
    meas(24'h000100, 24'h000300, 1'b0, ta);
    chk("muxDelta", 24'(ta), 24'(2 * MUXC));
    wr(OFS_CHMAP_LOW, slot(0, 3'h5, 3'h1, 1'b1, 1'b1));
    meas(24'h000001, 24'h000003, 1'b0, ta);
    chk("outDelta", 24'(ta), 24'(2 * OUTC));
    chk("pins", 24'(pinSeen), 24'h000020);
    chk("pinsIdle", 24'(outPins), 24'h000000);
    meas(24'h010000, 24'h030000, 1'b1, ta);
    chk("autoDelta", 24'(ta), 24'(2 * AUTOC));
    // Three channels, own bounds, slow converter, write refused
    wr(OFS_DELAY_CFG, 24'h000000);
    wr(OFS_BOUND_CH0, 24'h000064);
    wr(OFS_BOUND_CH1, 24'hFFFFFB);
    wr(OFS_BOUND_CH2, 24'h000028);
    wr(OFS_CHMAP_LOW, slot(0, 3'h0, 3'h2, 1'b1, 1'b0)
                    | slot(1, 3'h1, 3'h3, 1'b1, 1'b0)
                    | slot(2, 3'h3, 3'h1, 1'b1, 1'b0));
    slow <= 1'b1;
    for (j = 0; j < 2; j++) begin
      resVal <= j ? 24'hFFFFFD : 24'h000032;
      runTo(ta);
      wr(OFS_CHMAP_LOW, 24'hFFFFFF);
      idle();
      chk("hitMask", 24'(hitMask), j ? 24'h000005 : 24'h000001);
      chk("chSeq", 24'(chSeq), 24'h000021);
    end
    rdc(OFS_CHMAP_LOW, 24'h662E0A);
    conclude();
  end
endmodule
`default_nettype wire
